// *** hdl/rtc_pkg.sv ***
package rtc_pkg;
	localparam int              RTC_ADDR_W       = 12;
	localparam logic [11:0]     RTC_OFF_RTB_LO   = 12'h0020;
	localparam logic [11:0]     RTC_OFF_RTB_HI   = 12'h0024;
	localparam logic [11:0]     RTC_OFF_CCMD_LO  = 12'h0028;
	localparam logic [11:0]     RTC_OFF_CCMD_HI  = 12'h002c;
	localparam logic [11:0]     RTC_OFF_GCMD     = 12'h0030;
	localparam logic [11:0]     RTC_OFF_GSTS     = 12'h0034;
	localparam logic [11:0]     RTC_OFF_CAP      = 12'h0038;
	localparam int              RTC_ROOT_LSB     = 12;
	localparam int              RTC_REQ_HI_BIT   = 31;
	localparam int              RTC_REQ_GRAN_LSB = 29;
	localparam int              RTC_ACT_GRAN_LSB = 27;
	localparam int              RTC_SET_ROOT_BIT = 30;
	localparam int              RTC_ROOT_STS_BIT = 30;
	localparam int              RTC_FLUSH_CAP_BIT = 4;
	localparam logic [63:0]     RTC_RTB_RESET    = 64'h0000_0000_0000_0000;
	localparam logic [1:0]      RTC_GRAN_RSVD    = 2'h0;
	localparam logic [1:0]      RTC_GRAN_GLOBAL  = 2'h1;
	localparam logic [1:0]      RTC_GRAN_DOMAIN  = 2'h2;
	localparam logic [1:0]      RTC_GRAN_DEVICE  = 2'h3;
	localparam int              RTC_FLUSH_CYC    = 4;
	localparam int              RTC_INVAL_CYC    = 8;
	localparam int              RTC_LOAD_CYC     = 2;

	typedef enum logic [1:0] {
		RTC_IDLE  = 2'b00,
		RTC_FLUSH = 2'b01,
		RTC_INVAL = 2'b10
	} rtc_state_type;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} rtc_bus_type;
endpackage

// *** hdl/rtc_regs.sv ***
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module rtc_regs
	import rtc_pkg::*;
#(
	parameter int   HOST_ADDR_W = 48,
	parameter logic FLUSH_REQ   = 1'b1
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire rtc_bus_type bus,
	output logic      [31:0] rdata,
	output logic      [63:0] root_table_address,
	output logic             flush_req_ff,
	output logic             inval_busy_ff
);
	localparam logic [63:0] ADDR_MASK =
		((64'h1 << HOST_ADDR_W) - 64'h1) & ~64'h0000_0000_0000_0fff;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	logic [63:0]   rtb;
	logic          req_bit_ff;
	logic [1:0]    req_gran_ff;
	logic [1:0]    act_gran_ff;
	logic          root_sts_ff;
	logic [3:0]    load_cnt_ff;
	logic [3:0]    op_cnt_ff;
	rtc_state_type state_ff;
	rtc_state_type nxt_state;
	logic          wr_top;
	logic          start;
	logic          done;
	logic          set_root;
	logic [1:0]    gran_used;

	// Staging words for the root base; not used until adopted
	rtc_word_reg #(.W(32), .KEEP(ADDR_MASK[31:0])) u_rtb_lo (
		.core_clk (core_clk),
		.rst      (rst),
		.we       (bus.wr && hit(bus.addr, RTC_OFF_RTB_LO)),
		.wdata    (bus.wdata),
		.q        (rtb[31:0])
	);
	rtc_word_reg #(.W(32), .KEEP(ADDR_MASK[63:32])) u_rtb_hi (
		.core_clk (core_clk),
		.rst      (rst),
		.we       (bus.wr && hit(bus.addr, RTC_OFF_RTB_HI)),
		.wdata    (bus.wdata),
		.q        (rtb[63:32])
	);

	assign set_root = bus.wr && hit(bus.addr, RTC_OFF_GCMD) &&
		bus.wdata[RTC_SET_ROOT_BIT];
	assign wr_top = bus.wr && hit(bus.addr, RTC_OFF_CCMD_HI);
	assign start  = wr_top && bus.wdata[RTC_REQ_HI_BIT] && !req_bit_ff;
	assign done   = (state_ff == RTC_INVAL) && (op_cnt_ff == 4'h0);
	// Reserved request falls back to global, a coarser scope
	assign gran_used = (req_gran_ff == RTC_GRAN_RSVD) ?
		RTC_GRAN_GLOBAL : req_gran_ff;

	// Root pointer adoption and its status
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			root_table_address <= RTC_RTB_RESET;
			root_sts_ff        <= 1'b0;
			load_cnt_ff        <= 4'h0;
		end else if (set_root) begin
			root_sts_ff <= 1'b0;
			load_cnt_ff <= 4'(RTC_LOAD_CYC);
		end else if (load_cnt_ff == 4'h1) begin
			root_table_address <= rtb;
			root_sts_ff        <= 1'b1;
			load_cnt_ff        <= 4'h0;
		end else if (load_cnt_ff != 4'h0) begin
			load_cnt_ff <= load_cnt_ff - 4'h1;
		end
	end

	// Invalidation sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RTC_IDLE: begin
				if (start) begin
					nxt_state = FLUSH_REQ ? RTC_FLUSH : RTC_INVAL;
				end
			end
			RTC_FLUSH: begin
				if (op_cnt_ff == 4'h0) begin
					nxt_state = RTC_INVAL;
				end
			end
			RTC_INVAL: begin
				if (op_cnt_ff == 4'h0) begin
					nxt_state = RTC_IDLE;
				end
			end
			default: nxt_state = RTC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff  <= RTC_IDLE;
			op_cnt_ff <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			if (start) begin
				op_cnt_ff <= FLUSH_REQ ? 4'(RTC_FLUSH_CYC - 1) :
					4'(RTC_INVAL_CYC - 1);
			end else if (state_ff == RTC_FLUSH && op_cnt_ff == 4'h0) begin
				op_cnt_ff <= 4'(RTC_INVAL_CYC - 1);
			end else if (op_cnt_ff != 4'h0) begin
				op_cnt_ff <= op_cnt_ff - 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			req_bit_ff  <= 1'b0;
			req_gran_ff <= RTC_GRAN_RSVD;
			act_gran_ff <= RTC_GRAN_RSVD;
		end else if (start) begin
			req_bit_ff  <= 1'b1;
			req_gran_ff <= bus.wdata[RTC_REQ_GRAN_LSB +: 2];
		end else if (done) begin
			req_bit_ff  <= 1'b0;
			act_gran_ff <= gran_used;
		end else if (wr_top && !req_bit_ff) begin
			req_gran_ff <= bus.wdata[RTC_REQ_GRAN_LSB +: 2];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flush_req_ff  <= 1'b0;
			inval_busy_ff <= 1'b0;
		end else begin
			flush_req_ff  <= (nxt_state == RTC_FLUSH);
			inval_busy_ff <= (nxt_state != RTC_IDLE);
		end
	end

	// Read port: data stand one cycle after the strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (bus.rd) begin
			case (bus.addr)
				RTC_OFF_RTB_LO:  rdata <= rtb[31:0];
				RTC_OFF_RTB_HI:  rdata <= rtb[63:32];
				RTC_OFF_CCMD_HI: rdata <= {req_bit_ff, req_gran_ff,
					act_gran_ff, 27'h000_0000};
				RTC_OFF_GSTS:    rdata <= 32'(root_sts_ff) << RTC_ROOT_STS_BIT;
				RTC_OFF_CAP:     rdata <= 32'(FLUSH_REQ) << RTC_FLUSH_CAP_BIT;
				default:         rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	sequence s_req;
		start;
	endsequence
	sequence s_flush_then_inval;
		flush_req_ff [*4] ##1 !flush_req_ff;
	endsequence

	a_low_bits_zero: assert property (@(posedge core_clk) disable iff (rst)
		bus.rd && hit(bus.addr, RTC_OFF_RTB_LO) |=> rdata[11:0] == 12'h000)
		else $error("root base low bits not zero");
	a_high_bits_gone: assert property (@(posedge core_clk) disable iff (rst)
		(rtb & ~ADDR_MASK) == 64'h0)
		else $error("unimplemented address bits kept");
	a_base_held: assert property (@(posedge core_clk) disable iff (rst)
		load_cnt_ff != 4'h1 |=> $stable(root_table_address))
		else $error("base changed without command");
	a_base_readback: assert property (@(posedge core_clk) disable iff (rst)
		bus.wr && hit(bus.addr, RTC_OFF_RTB_HI) ##1 !bus.wr ##1
		bus.rd && hit(bus.addr, RTC_OFF_RTB_HI) |=>
		rdata == ($past(bus.wdata, 3) & ADDR_MASK[63:32]))
		else $error("base read not last written");
	a_req_starts: assert property (@(posedge core_clk) disable iff (rst)
		s_req |=> req_bit_ff && inval_busy_ff)
		else $error("request did not start");
	a_req_clears: assert property (@(posedge core_clk) disable iff (rst)
		$rose(req_bit_ff) |-> ##[1:12] !req_bit_ff)
		else $error("request bit not cleared");
	a_act_gran: assert property (@(posedge core_clk) disable iff (rst)
		$fell(req_bit_ff) |-> act_gran_ff != RTC_GRAN_RSVD &&
		act_gran_ff >= $past(req_gran_ff))
		else $error("bad actual granularity");
	a_flush_first: assert property (@(posedge core_clk) disable iff (rst)
		(s_req and FLUSH_REQ) |=> s_flush_then_inval)
		else $error("flush not before invalidate");
	a_root_sts_seq: assert property (@(posedge core_clk) disable iff (rst)
		set_root |=> !root_sts_ff [*2] ##1 root_sts_ff)
		else $error("pointer status sequence wrong");
	a_busy_hold: assert property (@(posedge core_clk) disable iff (rst)
		req_bit_ff && !done |=> req_bit_ff && $stable(req_gran_ff))
		else $error("busy state disturbed");
endmodule

// *** hdl/rtc_word_reg.sv ***
`timescale 1ns/100ps
module rtc_word_reg
	import rtc_pkg::*;
#(
	parameter int          W     = 32,
	parameter logic [31:0] RST   = 32'h0000_0000,
	parameter logic [31:0] KEEP  = 32'hffff_ffff
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         we,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] q
);
	// Registered storage word with a mask of implemented bits; q takes the masked write at the next clock edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= RST[W-1:0];
		end else if (we) begin
			q <= wdata & KEEP[W-1:0];
		end
	end
endmodule

// *** verif/rtc_regs_bench.sv ***
`timescale 1ns/100ps
module rtc_regs_bench
	import rtc_pkg::*;
;
	logic        core_clk;
	logic        rst;
	rtc_bus_type bus_s;
	logic [31:0] rdata;
	logic [63:0] root_table_address;
	logic        flush_req_ff;
	logic        inval_busy_ff;
	int          err_total;
	int          total_checks;
	logic [31:0] lo;
	logic [31:0] hi;
	logic [31:0] d;
	logic [1:0]  g;
	logic [1:0]  act;
	int          n;

	rtc_regs #(
		.HOST_ADDR_W (48),
		.FLUSH_REQ   (1'b1)
	) rtc_regs_inst (
		.core_clk           (core_clk),
		.rst                (rst),
		.bus                (bus_s),
		.rdata              (rdata),
		.root_table_address (root_table_address),
		.flush_req_ff       (flush_req_ff),
		.inval_busy_ff      (inval_busy_ff)
	);

	always #25 core_clk = ~core_clk;

	task automatic results();
		if (err_total == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] exp,
			input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge core_clk);
		bus_s.addr  <= a;
		bus_s.wdata <= v;
		bus_s.wr    <= 1'b1;
		@(posedge core_clk);
		bus_s.wr    <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge core_clk);
		bus_s.addr <= a;
		bus_s.rd   <= 1'b1;
		@(posedge core_clk);
		bus_s.rd   <= 1'b0;
		@(negedge core_clk);
		v = rdata;
	endtask

	initial begin
		#(50 * 4000);
		err_total++;
		results();
	end

	initial begin
		core_clk     = 1'b0;
		rst          = 1'b1;
		bus_s        = '0;
		err_total    = 0;
		total_checks = 0;
		void'($urandom(62070));
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rd(12'h0020, d);
		chk("rtb_lo_rst", 64'h0, 64'(d));
		rd(12'h0034, d);
		chk("root_sts_rst", 64'h0, 64'(d[30]));
		rd(12'h0038, d);
		chk("flush_cap", 64'h1, 64'(d[4]));
		rd(12'h0100, d);
		chk("unmapped", 64'h0, 64'(d));
		rd(12'h0028, d);
		chk("ccmd_lo", 64'h0, 64'(d));
		lo = $urandom;
		hi = $urandom;
		wr(12'h0020, lo);
		wr(12'h0024, hi);
		rd(12'h0024, d);
		chk("rtb_hi", 64'(hi & 32'h0000_ffff), 64'(d));
		rd(12'h0020, d);
		chk("rtb_lo", 64'(lo & 32'hffff_f000), 64'(d));
		chk("addr_kept", 64'h0, root_table_address);
		wr(12'h0030, 32'h4000_0000);
		repeat (3) @(posedge core_clk);
		rd(12'h0034, d);
		chk("root_sts_set", 64'h1, 64'(d[30]));
		chk("addr_new", {hi & 32'h0000_ffff, lo & 32'hffff_f000},
			root_table_address);
		for (int i = 0; i < 4; i++) begin
			g   = 2'(i);
			act = (g == RTC_GRAN_RSVD) ? RTC_GRAN_GLOBAL : g;
			wr(12'h002c, {1'b1, g, 29'($urandom) & 29'h07ff_ffff});
			@(negedge core_clk);
			chk("flush", 64'h1, 64'(flush_req_ff));
			chk("busy", 64'h1, 64'(inval_busy_ff));
			wr(12'h002c, {1'b1, ~g, 29'h0});
			rd(12'h002c, d);
			chk("req_set", 64'h1, 64'(d[31]));
			n = 0;
			while (d[31] !== 1'b0 && n < 40) begin
				rd(12'h002c, d);
				n++;
			end
			chk("req_clr", 64'h0, 64'(d[31]));
			// Lookaside cache flush would follow; outside this block
			chk("req_gran", 64'(g), 64'(d[30:29]));
			chk("act_gran", 64'(act), 64'(d[28:27]));
			chk("idle", 64'h0, 64'(inval_busy_ff));
		end
		results();
	end
endmodule
